// [fsel_inputs.sv]
// Partner model: terminal inputs feeding the setpoint selector.
// Assumes the bench asks for a pin pattern; pins follow at the next edge.
`timescale 1ns/100ps
`default_nettype none
module fsel_inputs (
  input wire logic clk,
  input wire logic [5:0] want,
  output logic [5:0] pins
);
  // Registered so the selector never sees a change between edges
  always_ff @(posedge clk) begin
    pins <= want;
  end
endmodule
`default_nettype wire

// [fsel_pkg.sv]
// Constants shared by the fixed setpoint selector and its tick divider.
// Frequencies are held in units of 0.01 Hz; APB data is 32 bits wide.
package fsel_pkg;

  localparam int ADDR_W = 8;
  localparam int FREQ_W = 16;
  localparam int NUM_SP = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_SP0 = 8'h00;
  localparam logic [7:0] OFS_MAX = 8'h20;
  localparam logic [7:0] OFS_SRC = 8'h24;
  localparam logic [7:0] OFS_ASSIGN = 8'h28;
  localparam logic [7:0] OFS_ACCEL = 8'h2C;
  localparam logic [7:0] OFS_DECEL = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // Status register field positions
  localparam int STS_IDX_LSB = 0;
  localparam int STS_FIXED_BIT = 3;
  localparam int STS_FREQ_LSB = 16;

  // Reset values (5.00 Hz .. 50.00 Hz)
  localparam logic [NUM_SP-1:0][FREQ_W-1:0] SP_RST = {
    16'h1388, 16'h0FA0, 16'h0BB8, 16'h09C4,
    16'h07D0, 16'h05DC, 16'h03E8, 16'h01F4};
  localparam logic [15:0] MAX_RST = 16'h1388;
  localparam logic [7:0] SRC_RST = 8'h01;
  localparam logic [2:0] ASSIGN_RST = 3'h0;
  localparam logic [15:0] ACCEL_RST = 16'h001E;
  localparam logic [15:0] DECEL_RST = 16'h001E;

  // Select input positions on the digital input bus (bit 0 = first input)
  localparam int SEL_A_BIT = 2;
  localparam int SEL_B_BIT = 3;
  localparam logic [2:0] ASSIGN_MAX = 3'h6;

  // Timing: ramp tick every 10 us, ramp time unit 0.1 s
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int RAMP_UNIT_MS = 100;
  localparam int TICKS_PER_UNIT = (RAMP_UNIT_MS * 1000000) / TICK_NS;

endpackage

// [fsel_tick.sv]
// Free-running divider giving a one-cycle enable every COUNT clocks.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module fsel_tick #(
  parameter int COUNT = 1000
) (
  input wire logic CLK,
  input wire logic RST,
  output logic TICK
);
  logic [15:0] cnt_r;
  wire logic last = (cnt_r == 16'(COUNT - 1));

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_r <= 16'h0000;
      TICK <= 1'b0;
    end else begin
      cnt_r <= last ? 16'h0000 : cnt_r + 16'h0001;
      TICK <= last;
    end
  end
endmodule
`default_nettype wire

// [fsel_top.sv]
// Fixed frequency setpoint selector with ramped frequency reference.
// Assumes APB master on CLK, digital inputs synchronous to CLK.
//
// What this block does
// - Setpoints range from zero to the maximum frequency; a write above it stores the maximum.
// - Setpoint zero applies only when the source selection setting is zero.
// - First select input alone selects setpoint one.
// - Second select input alone selects setpoint two.
// - First and second select inputs together select setpoint three.
// - Setpoints four to seven need the third select input assigned to a pin.
// - Second and third select inputs select setpoint six.
// - All three select inputs select setpoint seven.
// - A selected fixed setpoint overrides any other reference source.
// - Changes between setpoints follow the acceleration and deceleration ramps.
// - Setpoints stay writable while running and take effect at once.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fsel_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [5:0] DIGITAL_IN,
  input wire logic [15:0] OTHER_REF,
  output logic [15:0] FREQ_REF,
  output logic [15:0] TARGET_FREQ,
  output logic [2:0] SETPOINT_INDEX,
  output logic FIXED_ACTIVE
);

  // Configuration registers
  logic [15:0] sp_r [0:7];
  logic [15:0] max_r;
  logic [7:0] src_r;
  logic [2:0] assign_r;
  logic [15:0] accel_r;
  logic [15:0] decel_r;
  logic [31:0] acc_r;
  logic pready_r;

  // APB decode
  wire logic setup = PSEL && !PENABLE;
  wire logic wr_en = PSEL && PENABLE && PREADY && PWRITE;
  wire logic hit_sp = (PADDR < fsel_pkg::OFS_MAX) && (PADDR[1:0] == 2'b00);
  wire logic [2:0] sp_idx = PADDR[4:2];
  wire logic hit_max = (PADDR == fsel_pkg::OFS_MAX);
  wire logic hit_src = (PADDR == fsel_pkg::OFS_SRC);
  wire logic hit_asg = (PADDR == fsel_pkg::OFS_ASSIGN);
  wire logic hit_acc = (PADDR == fsel_pkg::OFS_ACCEL);
  wire logic hit_dec = (PADDR == fsel_pkg::OFS_DECEL);
  wire logic hit_sts = (PADDR == fsel_pkg::OFS_STATUS);
  wire logic mapped = hit_sp || hit_max || hit_src || hit_asg || hit_acc || hit_dec || hit_sts;
  wire logic wr_bad = PWRITE && hit_sts;
  // Writes are clamped so a written setpoint never exceeds the maximum at the time of the write
  wire logic [15:0] wr_clamped = (PWDATA[15:0] > max_r) ? max_r : PWDATA[15:0];

  wire logic [31:0] status_word = {FREQ_REF, 12'h000, FIXED_ACTIVE, SETPOINT_INDEX};
  wire logic [31:0] rd_mux =
    hit_sp ? {16'h0000, sp_r[sp_idx]} :
    hit_max ? {16'h0000, max_r} :
    hit_src ? {24'h000000, src_r} :
    hit_asg ? {29'h00000000, assign_r} :
    hit_acc ? {16'h0000, accel_r} :
    hit_dec ? {16'h0000, decel_r} :
    hit_sts ? status_word : 32'h00000000;

  // Setpoint selection
  wire logic sel_a = DIGITAL_IN[fsel_pkg::SEL_A_BIT];
  wire logic sel_b = DIGITAL_IN[fsel_pkg::SEL_B_BIT];
  // Third input exists only when its assignment names a real pin
  wire logic third_ok = (assign_r != 3'h0) && (assign_r <= fsel_pkg::ASSIGN_MAX);
  wire logic [2:0] third_pin = assign_r - 3'h1;
  // Padded to eight so an unassigned code never indexes past the pins
  wire logic [7:0] pins_ext = {2'b00, DIGITAL_IN};
  wire logic sel_c = third_ok && pins_ext[third_pin];
  wire logic [2:0] idx_nxt = {sel_c, sel_b, sel_a};
  wire logic fixed_nxt = (idx_nxt != 3'h0) || (src_r == 8'h00);
  // Clamp again on use: lowering the maximum must also limit older setpoints
  wire logic [15:0] sp_raw = sp_r[idx_nxt];
  wire logic [15:0] sp_sel = (sp_raw > max_r) ? max_r : sp_raw;
  wire logic [15:0] other_c = (OTHER_REF > max_r) ? max_r : OTHER_REF;
  wire logic [15:0] target_nxt = fixed_nxt ? sp_sel : other_c;

  // Ramp generator
  logic tick;
  wire logic ramp_up = FREQ_REF < TARGET_FREQ;
  wire logic ramp_dn = FREQ_REF > TARGET_FREQ;
  wire logic [15:0] rtime = ramp_up ? accel_r : decel_r;
  wire logic [31:0] thr = 32'(rtime) * 32'(fsel_pkg::TICKS_PER_UNIT);
  wire logic [31:0] acc_sum = acc_r + 32'(max_r);
  wire logic step = acc_sum >= thr;
  wire logic [31:0] acc_left = acc_sum - thr;
  // A huge maximum against a short ramp saturates at one step per tick
  wire logic [31:0] acc_keep = (acc_left >= thr) ? 32'h00000000 : acc_left;
  wire logic moving = ramp_up || ramp_dn;
  wire logic [15:0] freq_step = ramp_up ? FREQ_REF + 16'h0001 : FREQ_REF - 16'h0001;
  wire logic [15:0] freq_nxt =
    !(tick && moving) ? FREQ_REF :
    (rtime == 16'h0000) ? TARGET_FREQ :
    step ? freq_step : FREQ_REF;
  wire logic [31:0] acc_nxt =
    !moving ? 32'h00000000 :
    !tick ? acc_r :
    (rtime == 16'h0000) ? 32'h00000000 :
    step ? acc_keep : acc_sum;

  fsel_tick #(
    .COUNT(fsel_pkg::TICK_CYCLES)
  ) i_fsel_tick (
    .CLK(CLK),
    .RST(RST),
    .TICK(tick)
  );

  // APB handshake: one wait-free access phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_r <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
        PSLVERR <= !mapped || wr_bad;
      end
    end
  end
  assign PREADY = pready_r;

  // Setpoints are written at any time, running or not
  always_ff @(posedge CLK) begin
    for (int i = 0; i < fsel_pkg::NUM_SP; i++) begin
      if (RST) begin
        sp_r[i] <= fsel_pkg::SP_RST[i];
      end else if (wr_en && hit_sp && (sp_idx == 3'(i))) begin
        sp_r[i] <= wr_clamped;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      max_r <= fsel_pkg::MAX_RST;
      src_r <= fsel_pkg::SRC_RST;
      assign_r <= fsel_pkg::ASSIGN_RST;
      accel_r <= fsel_pkg::ACCEL_RST;
      decel_r <= fsel_pkg::DECEL_RST;
    end else if (wr_en) begin
      if (hit_max) max_r <= PWDATA[15:0];
      if (hit_src) src_r <= PWDATA[7:0];
      if (hit_asg) assign_r <= PWDATA[2:0];
      if (hit_acc) accel_r <= PWDATA[15:0];
      if (hit_dec) decel_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SETPOINT_INDEX <= 3'h0;
      FIXED_ACTIVE <= 1'b0;
      TARGET_FREQ <= 16'h0000;
      FREQ_REF <= 16'h0000;
      acc_r <= 32'h00000000;
    end else begin
      SETPOINT_INDEX <= idx_nxt;
      FIXED_ACTIVE <= fixed_nxt;
      TARGET_FREQ <= target_nxt;
      FREQ_REF <= freq_nxt;
      acc_r <= acc_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_clamp;
    $stable(max_r) |-> (TARGET_FREQ <= max_r);
  endproperty
  a_clamp: assert property (p_clamp) else $error("target above maximum");

  property p_zero_src;
    (!sel_a && !sel_b && !sel_c && src_r != 8'h00) |=> !FIXED_ACTIVE;
  endproperty
  a_zero_src: assert property (p_zero_src) else $error("setpoint zero used wrongly");

  property p_sel_one;
    (sel_a && !sel_b && !sel_c) |=> (SETPOINT_INDEX == 3'h1) && FIXED_ACTIVE;
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("setpoint one not selected");

  property p_sel_two;
    (!sel_a && sel_b && !sel_c) |=> (SETPOINT_INDEX == 3'h2) && FIXED_ACTIVE;
  endproperty
  a_sel_two: assert property (p_sel_two) else $error("setpoint two not selected");

  property p_sel_three;
    (sel_a && sel_b && !sel_c) |=> (SETPOINT_INDEX == 3'h3);
  endproperty
  a_sel_three: assert property (p_sel_three) else $error("setpoint three not selected");

  property p_third_off;
    (assign_r == 3'h0 || assign_r == 3'h7) |=> !SETPOINT_INDEX[2];
  endproperty
  a_third_off: assert property (p_third_off) else $error("upper setpoint unassigned");

  property p_sel_six;
    (!sel_a && sel_b && sel_c) |=> (SETPOINT_INDEX == 3'h6);
  endproperty
  a_sel_six: assert property (p_sel_six) else $error("setpoint six not selected");

  property p_sel_seven;
    (sel_a && sel_b && sel_c) |=> (SETPOINT_INDEX == 3'h7);
  endproperty
  a_sel_seven: assert property (p_sel_seven) else $error("setpoint seven not selected");

  property p_sel_four;
    (!sel_a && !sel_b && sel_c) |=> (SETPOINT_INDEX == 3'h4);
  endproperty
  a_sel_four: assert property (p_sel_four) else $error("setpoint four not selected");

  property p_priority;
    (fixed_nxt && OTHER_REF != sp_sel) |=> (TARGET_FREQ == $past(sp_sel));
  endproperty
  a_priority: assert property (p_priority) else $error("fixed setpoint lost priority");

  property p_ramp;
    (FREQ_REF != $past(FREQ_REF)) && ($past(rtime) != 16'h0000) |->
      (FREQ_REF == $past(FREQ_REF) + 16'h0001) || (FREQ_REF + 16'h0001 == $past(FREQ_REF));
  endproperty
  a_ramp: assert property (p_ramp) else $error("frequency stepped off ramp");

  property p_live_write;
    (wr_en && hit_sp) |=> (sp_r[$past(sp_idx)] == $past(wr_clamped));
  endproperty
  a_live_write: assert property (p_live_write) else $error("setpoint write lost");

  property p_no_fixed;
    !fixed_nxt |=> !FIXED_ACTIVE && (TARGET_FREQ == $past(other_c));
  endproperty
  a_no_fixed: assert property (p_no_fixed) else $error("normal reference not used");

  property p_ready_pulse;
    setup |=> PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("no ready after setup");

  property p_ready_one;
    (PREADY && PENABLE) |=> !PREADY;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");

  property p_idle_ready;
    !PSEL |=> !PREADY;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("ready while idle");

  property p_wr_bad;
    (setup && PWRITE && hit_sts) |=> PSLVERR;
  endproperty
  a_wr_bad: assert property (p_wr_bad) else $error("status write not refused");

  property p_unmapped_rd;
    (setup && !mapped && !PWRITE) |=> PSLVERR && (PRDATA == 32'h00000000);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not refused");

  property p_rd_sp;
    (setup && !PWRITE && hit_sp) |=> (PRDATA == {16'h0000, $past(sp_r[sp_idx])});
  endproperty
  a_rd_sp: assert property (p_rd_sp) else $error("setpoint read wrong");

  property p_sts_read;
    (setup && !PWRITE && hit_sts) |=> (PRDATA == $past(status_word));
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status read wrong");

  property p_max_write;
    (wr_en && hit_max) |=> (max_r == $past(PWDATA[15:0]));
  endproperty
  a_max_write: assert property (p_max_write) else $error("maximum write lost");

  property p_src_write;
    (wr_en && hit_src) |=> (src_r == $past(PWDATA[7:0]));
  endproperty
  a_src_write: assert property (p_src_write) else $error("source write lost");

  property p_asg_write;
    (wr_en && hit_asg) |=> (assign_r == $past(PWDATA[2:0]));
  endproperty
  a_asg_write: assert property (p_asg_write) else $error("assignment write lost");

  property p_third_pin;
    (assign_r == 3'h5 && DIGITAL_IN[4] && !sel_a && !sel_b) |=> (SETPOINT_INDEX == 3'h4);
  endproperty
  a_third_pin: assert property (p_third_pin) else $error("fifth input not third select");

  property p_sel_five;
    (sel_a && !sel_b && sel_c) |=> (SETPOINT_INDEX == 3'h5);
  endproperty
  a_sel_five: assert property (p_sel_five) else $error("setpoint five not selected");

  property p_sel_zero;
    (!sel_a && !sel_b && !sel_c && src_r == 8'h00) |=>
      FIXED_ACTIVE && (TARGET_FREQ == $past(sp_sel));
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("setpoint zero not applied");

  property p_tick_gap;
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ramp tick too long");

  property p_tick_hold;
    !tick |=> (FREQ_REF == $past(FREQ_REF));
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("frequency moved off tick");

  property p_settled;
    !moving |=> (FREQ_REF == $past(FREQ_REF));
  endproperty
  a_settled: assert property (p_settled) else $error("frequency moved at target");

  property p_up_bound;
    ramp_up |=> (FREQ_REF <= $past(TARGET_FREQ));
  endproperty
  a_up_bound: assert property (p_up_bound) else $error("ramp up overshoot");

  property p_dn_bound;
    ramp_dn |=> (FREQ_REF >= $past(TARGET_FREQ));
  endproperty
  a_dn_bound: assert property (p_dn_bound) else $error("ramp down overshoot");

  property p_zero_time;
    (tick && moving && rtime == 16'h0000) |=> (FREQ_REF == $past(TARGET_FREQ));
  endproperty
  a_zero_time: assert property (p_zero_time) else $error("zero ramp time no jump");

endmodule
`default_nettype wire

// [test_fixed_frequency_setpoint_select.sv]
// Self-checking bench for the fixed setpoint selector.
// Assumes fsel_top and fsel_inputs; APB master and scoreboard live here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module test_fixed_frequency_setpoint_select;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FIXED_ACTIVE, look;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [5:0] want, DIGITAL_IN;
  logic [15:0] OTHER_REF, FREQ_REF, TARGET_FREQ, v;
  logic [2:0] SETPOINT_INDEX, ix;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [15:0] sp[8];
  int fails, n_tests, k;

  fsel_top i_fsel_top (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DIGITAL_IN(DIGITAL_IN), .OTHER_REF(OTHER_REF),
    .FREQ_REF(FREQ_REF), .TARGET_FREQ(TARGET_FREQ), .SETPOINT_INDEX(SETPOINT_INDEX),
    .FIXED_ACTIVE(FIXED_ACTIVE));
  fsel_inputs i_fsel_inputs (.clk(CLK), .want(want), .pins(DIGITAL_IN));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Scoreboard: takes the oldest note whenever a transfer or a check completes
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY) begin
      e = q.pop_front();
      if (e[33]) `CHK("wr_err", e[32], PSLVERR)
      else `CHK("rd", e[32:0], {PSLVERR, PRDATA})
    end
    if (look) begin
      e = q.pop_front();
      `CHK("sel", e[19:0], {FIXED_ACTIVE, SETPOINT_INDEX, TARGET_FREQ})
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    int n;
    q.push_back({w, x});
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        give_verdict();
      end
      @(posedge CLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task sel(input logic [5:0] p, input logic [19:0] x);
    want <= p;
    repeat (3) @(posedge CLK);
    q.push_back({14'h0, x});
    look <= 1'b1;
    @(posedge CLK);
    look <= 1'b0;
  endtask

  initial begin
    #300000;
    fails++;
    give_verdict();
  end

  initial begin
    void'($urandom(94876));
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    want = 6'h00;
    OTHER_REF = 16'h0100;
    look = 1'b0;
    fails = 0;
    n_tests = 0;
    for (k = 0; k < 8; k++) sp[k] = fsel_pkg::SP_RST[k];
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    for (k = 0; k < 8; k++) apb(1'b0, 8'(4 * k), 32'h0, {17'h0, sp[k]});
    for (k = 0; k < 7; k++) begin
      v = 16'($urandom % 5000);
      sp[k] = v;
      apb(1'b1, 8'(4 * k), {16'h0, v}, 33'h0);
    end
    // Over-range write lands on the maximum
    apb(1'b1, 8'h1C, 32'h0000FFFF, 33'h0);
    sp[7] = fsel_pkg::MAX_RST;
    for (k = 0; k < 8; k++) apb(1'b0, 8'(4 * k), 32'h0, {17'h0, sp[k]});
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    apb(1'b1, fsel_pkg::OFS_STATUS, 32'hFFFF, {1'b1, 32'h0});
    apb(1'b1, fsel_pkg::OFS_ASSIGN, 32'h5, 33'h0);
    v = 16'($urandom);
    OTHER_REF <= v;
    if (v > fsel_pkg::MAX_RST) v = fsel_pkg::MAX_RST;
    for (k = 0; k < 8; k++) begin
      ix = 3'(k);
      sel({1'b0, ix, 2'b00} | (6'($urandom) & 6'h23), (k == 0) ? {4'h0, v} : {1'b1, ix, sp[k]});
    end
    apb(1'b1, fsel_pkg::OFS_SRC, 32'h0, 33'h0);
    sel(6'h00, {1'b1, 3'h0, sp[0]});
    apb(1'b1, fsel_pkg::OFS_ASSIGN, 32'h0, 33'h0);
    sel(6'h14, {1'b1, 3'h1, sp[1]});
    apb(1'b1, fsel_pkg::OFS_ACCEL, 32'h0, 33'h0);
    apb(1'b1, fsel_pkg::OFS_DECEL, 32'h0, 33'h0);
    sel(6'h0C, {1'b1, 3'h3, sp[3]});
    for (k = 0; k < 1100 && FREQ_REF !== sp[3]; k++) @(negedge CLK);
    `CHK("jump", sp[3], FREQ_REF)
    @(posedge CLK);
    // One step per tick at most, so a slow ramp must not reach the target
    apb(1'b1, fsel_pkg::OFS_ACCEL, 32'h1, 33'h0);
    apb(1'b1, fsel_pkg::OFS_ASSIGN, 32'h5, 33'h0);
    sel(6'h1C, {1'b1, 3'h7, sp[7]});
    repeat (2100) @(posedge CLK);
    @(negedge CLK);
    `CHK("ramp", 1'b1, FREQ_REF > sp[3] && FREQ_REF <= sp[3] + 16'd3)
    @(posedge CLK);
    apb(1'b1, 8'h1C, 32'h0800, 33'h0);
    sel(6'h1C, {1'b1, 3'h7, 16'h0800});
    give_verdict();
  end
endmodule
`default_nettype wire
